// *** ors_consts.vh ***
`ifndef ORS_CONSTS_VH
`define ORS_CONSTS_VH
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define ORS_ADDR_W 4
`define ORS_A_CTRL 4'h0
`define ORS_A_TARGET 4'h1
`define ORS_A_RATE 4'h2
`define ORS_A_TONDLY 4'h3
`define ORS_A_TOFFDLY 4'h4
`define ORS_A_PHASE 4'h5
`define ORS_A_STATMFR 4'h6
`define ORS_A_STATE 4'h7
`define ORS_A_MASK 4'h8
`define ORS_A_FREQ 4'h9
// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define ORS_CTRL_ON 0
`define ORS_CTRL_CLKDRV 1
`define ORS_PLL_BIT 4
`define ORS_PH_ARR_HI 2
`define ORS_PH_CLKMST 3
`define ORS_RATE_SKIP 16'h0FA0
`define ORS_RST_TARGET 16'h0400
`define ORS_RST_RATE 16'h0001
`define ORS_RST_FREQ 16'h0226
`define ORS_SYNC_MISS 12'hFA0
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define ORS_CLK_MHZ 125
`define ORS_STEP_US 100
`define ORS_LAT_US 270
`define ORS_DGL_US 250
`define ORS_STEP_CYC (`ORS_STEP_US * `ORS_CLK_MHZ)
`define ORS_LAT_CYC (`ORS_LAT_US * `ORS_CLK_MHZ)
`define ORS_DGL_CYC (`ORS_DGL_US * `ORS_CLK_MHZ)
// ------------------------------------------------------------
// States
// ------------------------------------------------------------
`define ORS_S_OFF 3'h0
`define ORS_S_LAT_ON 3'h1
`define ORS_S_TON 3'h2
`define ORS_S_RAMPUP 3'h3
`define ORS_S_RUN 3'h4
`define ORS_S_LAT_OFF 3'h5
`define ORS_S_TOFF 3'h6
`define ORS_S_RAMPDN 3'h7
`endif

// *** ors_output_ramp_sequencer.v ***
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// - Target moves in steps, at most one step per 100 us.
// - Transition rate code for 4 V/ms skips the soft-start ramp.
// - Soft-start ramps target from zero to programmed value; run state entered after the ramp.
// - Run input low or software off starts a controlled soft-off ramp.
// - End of soft-off commands power stage off regardless of output level.
// - Rail fault instantly turns off all phases of the rail, no ramp.
// - Fixed 270 us processing latency precedes every output change except the rail-fault shutdown.
// - Operations start within 50 us of nominal; timing resolution 100 us.
// - Bus-requested change counts latency from the bus STOP condition.
// - Turn-on delay before up ramp, turn-off delay before down ramp.
// - PWM clock locks to falling edge of external sync, 250 kHz to 1 MHz.
// - Without sync clock, PWM runs at programmed switching frequency.
// - PLL lock loss sets status bit 4 and pulls alert low unless masked; lock loss is ignored while the sequencer is off.
// - Writing one to status bit 4 clears the lock-loss flag.
// - Phase field [2:0] selects single-chip arrangement; slaves managed internally.
// - Phase register bit 3 makes the device expansion clock master.
// - In clock-master mode the power-good pin becomes a clock output.
// - Both chips carry the same arrangement field in dual-chip expansion.
// - Downstream stays disabled while run input is low from upstream.
// - Propagated undervoltage output is deglitched by a 250 us filter.
`include "ors_consts.vh"
module ors_output_ramp_sequencer (
  input wire sysClk,
  input wire rstn,
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [15:0] regRdData,
  input wire busStop,
  input wire runPin,
  input wire railFault,
  input wire syncIn,
  input wire pllLocked,
  input wire uvRaw,
  input wire powerGood0,
  input wire pwmClkInt,
  output reg [15:0] vTarget,
  output reg stageOn,
  output reg [7:0] phaseEnable,
  output reg [2:0] phaseArrangement,
  output reg [15:0] freqSelect,
  output reg useExtSync,
  output wire channelZeroPowerGoodOut,
  output wire channelZeroPowerGoodOe,
  output wire clkDriveOut,
  output wire alertLowOut,
  output wire alertLowOe,
  output reg uvFaultOut
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  reg [4:0] syncA_r;
  reg [4:0] syncB_r;
  wire runS = syncB_r[0];
  wire faultS = syncB_r[1];
  wire syncS = syncB_r[2];
  wire lockS = syncB_r[3];
  wire uvS = syncB_r[4];

  // Two flops on the run, fault, sync, lock and undervoltage pin inputs
  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      syncA_r <= 5'h00;
      syncB_r <= 5'h00;
    end else begin
      syncA_r <= {uvRaw, pllLocked, syncIn, railFault, runPin};
      syncB_r <= syncA_r;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg swOn_r;
  reg clkDrv_r;
  reg [15:0] targetReg_r;
  reg [15:0] rate_r;
  reg [15:0] tonDly_r;
  reg [15:0] toffDly_r;
  reg [3:0] phaseReg_r;
  reg pllLost_r;
  reg pllMask_r;
  reg [15:0] freq_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg swReq_r;
  reg syncS_d;
  reg lockS_d;
  reg [11:0] syncGap_r;

  // Sequencer state codes
  localparam [2:0] ST_OFF = `ORS_S_OFF;
  localparam [2:0] ST_LAT_ON = `ORS_S_LAT_ON;
  localparam [2:0] ST_TON = `ORS_S_TON;
  localparam [2:0] ST_RAMPUP = `ORS_S_RAMPUP;
  localparam [2:0] ST_RUN = `ORS_S_RUN;
  localparam [2:0] ST_LAT_OFF = `ORS_S_LAT_OFF;
  localparam [2:0] ST_TOFF = `ORS_S_TOFF;
  localparam [2:0] ST_RAMPDN = `ORS_S_RAMPDN;

  wire syncFall = syncS_d & ~syncS;
  wire syncPresent = (syncGap_r != `ORS_SYNC_MISS);
  wire lockLoss = lockS_d & ~lockS & (state_r != ST_OFF);
  wire wrClr = regWr && (regAddr == `ORS_A_STATMFR) && regWrData[`ORS_PLL_BIT];

  // Software writes and sticky lock-loss flag
  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      swOn_r <= 1'b0;
      clkDrv_r <= 1'b0;
      targetReg_r <= `ORS_RST_TARGET;
      rate_r <= `ORS_RST_RATE;
      tonDly_r <= 16'h0000;
      toffDly_r <= 16'h0000;
      phaseReg_r <= 4'h0;
      pllLost_r <= 1'b0;
      pllMask_r <= 1'b0;
      freq_r <= `ORS_RST_FREQ;
      swReq_r <= 1'b0;
    end else begin
      if (regWr) begin
        case (regAddr)
          `ORS_A_CTRL: begin
            swOn_r <= regWrData[`ORS_CTRL_ON];
            clkDrv_r <= regWrData[`ORS_CTRL_CLKDRV];
            swReq_r <= 1'b1;
          end
          `ORS_A_TARGET: begin
            targetReg_r <= regWrData;
            swReq_r <= 1'b1;
          end
          `ORS_A_RATE: rate_r <= regWrData;
          `ORS_A_TONDLY: tonDly_r <= regWrData;
          `ORS_A_TOFFDLY: toffDly_r <= regWrData;
          `ORS_A_PHASE: phaseReg_r <= regWrData[3:0];
          `ORS_A_MASK: pllMask_r <= regWrData[`ORS_PLL_BIT];
          `ORS_A_FREQ: freq_r <= regWrData;
          default: swOn_r <= swOn_r;
        endcase
      end else if (busStop) begin
        swReq_r <= 1'b0;
      end
      // Set wins over clear
      if (lockLoss) begin
        pllLost_r <= 1'b1;
      end else if (wrClr) begin
        pllLost_r <= 1'b0;
      end
    end
  end

  // Read data one cycle after strobe
  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      regRdData <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        `ORS_A_CTRL: regRdData <= {14'h0000, clkDrv_r, swOn_r};
        `ORS_A_TARGET: regRdData <= targetReg_r;
        `ORS_A_RATE: regRdData <= rate_r;
        `ORS_A_TONDLY: regRdData <= tonDly_r;
        `ORS_A_TOFFDLY: regRdData <= toffDly_r;
        `ORS_A_PHASE: regRdData <= {12'h000, phaseReg_r};
        `ORS_A_STATMFR: regRdData <= {11'h000, pllLost_r, 4'h0};
        `ORS_A_STATE: regRdData <= {11'h000, syncPresent, stageOn, state_r};
        `ORS_A_MASK: regRdData <= {11'h000, pllMask_r, 4'h0};
        `ORS_A_FREQ: regRdData <= freq_r;
        default: regRdData <= 16'h0000;
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // Sync detection and clock selection
  // ------------------------------------------------------------
  // Falling edges of sync mark an external clock as present
  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      syncS_d <= 1'b0;
      lockS_d <= 1'b0;
      syncGap_r <= `ORS_SYNC_MISS;
      useExtSync <= 1'b0;
      freqSelect <= `ORS_RST_FREQ;
      phaseArrangement <= 3'h0;
    end else begin
      syncS_d <= syncS;
      lockS_d <= lockS;
      if (syncFall) begin
        syncGap_r <= 12'h000;
      end else if (syncPresent) begin
        syncGap_r <= syncGap_r + 12'h001;
      end
      useExtSync <= syncPresent;
      freqSelect <= freq_r;
      phaseArrangement <= phaseReg_r[`ORS_PH_ARR_HI:0];
    end
  end

  // Clock master repurposes the power-good pin
  wire clkMaster = phaseReg_r[`ORS_PH_CLKMST];
  assign channelZeroPowerGoodOut = clkMaster ? pwmClkInt : 1'b0;
  assign channelZeroPowerGoodOe = clkMaster ? 1'b1 : ~powerGood0;
  assign clkDriveOut = clkDrv_r & pwmClkInt;
  assign alertLowOut = 1'b0;
  assign alertLowOe = pllLost_r & ~pllMask_r;

  // ------------------------------------------------------------
  // Undervoltage deglitch filter
  // ------------------------------------------------------------
  reg [15:0] dglCnt_r;

  // Output follows input only after it is stable for the filter time
  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      dglCnt_r <= 16'h0000;
      uvFaultOut <= 1'b0;
    end else if (uvS == uvFaultOut) begin
      dglCnt_r <= 16'h0000;
    end else if (dglCnt_r == `ORS_DGL_CYC - 1) begin
      uvFaultOut <= uvS;
      dglCnt_r <= 16'h0000;
    end else begin
      dglCnt_r <= dglCnt_r + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  reg [15:0] tick_r;
  reg [15:0] dlyCnt_r;
  reg [15:0] latCnt_r;
  reg stopSeen_r;
  wire tick = (tick_r == `ORS_STEP_CYC - 1);
  wire wantOn = runS & swOn_r;
  wire skipRamp = (rate_r >= `ORS_RATE_SKIP);
  wire latDone = (latCnt_r == `ORS_LAT_CYC - 1);

  // 100 us time base
  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      tick_r <= 16'h0000;
    end else if (tick) begin
      tick_r <= 16'h0000;
    end else begin
      tick_r <= tick_r + 16'h0001;
    end
  end

  // Next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (wantOn) state_nxt = ST_LAT_ON;
      end
      ST_LAT_ON: begin
        if (!wantOn) state_nxt = ST_OFF;
        else if (latDone) state_nxt = ST_TON;
      end
      ST_TON: begin
        if (!wantOn) state_nxt = ST_LAT_OFF;
        else if (dlyCnt_r >= tonDly_r) state_nxt = ST_RAMPUP;
      end
      ST_RAMPUP: begin
        if (!wantOn) state_nxt = ST_LAT_OFF;
        else if (skipRamp || vTarget >= targetReg_r) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (!wantOn) state_nxt = ST_LAT_OFF;
      end
      ST_LAT_OFF: begin
        if (latDone) state_nxt = ST_TOFF;
      end
      ST_TOFF: begin
        if (dlyCnt_r >= toffDly_r) state_nxt = ST_RAMPDN;
      end
      ST_RAMPDN: begin
        if (vTarget == 16'h0000) state_nxt = ST_OFF;
      end
      default: state_nxt = ST_OFF;
    endcase
  end

  // State, latency, delay and target stepping
  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_OFF;
      latCnt_r <= 16'h0000;
      dlyCnt_r <= 16'h0000;
      stopSeen_r <= 1'b0;
      vTarget <= 16'h0000;
      stageOn <= 1'b0;
      phaseEnable <= 8'h00;
    end else if (faultS) begin
      state_r <= ST_OFF;
      vTarget <= 16'h0000;
      stageOn <= 1'b0;
      phaseEnable <= 8'h00;
      latCnt_r <= 16'h0000;
      dlyCnt_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (swReq_r && busStop) begin
        stopSeen_r <= 1'b1;
      end else if (state_r != state_nxt) begin
        stopSeen_r <= 1'b0;
      end
      // Latency counts from STOP when a bus request is pending
      if (state_r != state_nxt || (swReq_r && !busStop)) begin
        latCnt_r <= 16'h0000;
      end else if (!latDone) begin
        latCnt_r <= latCnt_r + 16'h0001;
      end
      if (state_r != state_nxt) begin
        dlyCnt_r <= 16'h0000;
      end else if (tick) begin
        dlyCnt_r <= dlyCnt_r + 16'h0001;
      end
      case (state_r)
        ST_OFF: begin
          vTarget <= 16'h0000;
          stageOn <= 1'b0;
          phaseEnable <= 8'h00;
        end
        ST_RAMPUP: begin
          stageOn <= 1'b1;
          phaseEnable <= 8'hFF;
          if (skipRamp) begin
            vTarget <= targetReg_r;
          end else if (tick) begin
            vTarget <= (targetReg_r - vTarget > rate_r) ? vTarget + rate_r : targetReg_r;
          end
        end
        // New target only after the latency that follows the bus STOP
        ST_RUN: begin
          if (latDone && !swReq_r) begin
            vTarget <= targetReg_r;
          end
        end
        ST_RAMPDN: begin
          if (tick) begin
            vTarget <= (vTarget > rate_r) ? vTarget - rate_r : 16'h0000;
          end
          if (state_nxt == ST_OFF) begin
            stageOn <= 1'b0;
            phaseEnable <= 8'h00;
          end
        end
        default: vTarget <= vTarget;
      endcase
    end
  end

endmodule // ors_output_ramp_sequencer

// *** ors_ramp_checker.sv ***
`timescale 1ns/1ns
`include "ors_consts.vh"
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module ors_ramp_checker (
  input wire sysClk,
  input wire rstn,
  input wire [3:0] regAddr,
  input wire [15:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [15:0] regRdData,
  input wire runPin,
  input wire railFault,
  input wire pllLocked,
  input wire uvRaw,
  input wire [15:0] vTarget,
  input wire stageOn,
  input wire [7:0] phaseEnable,
  input wire [2:0] phaseArrangement,
  input wire [15:0] freqSelect,
  input wire alertLowOe,
  input wire uvFaultOut
);
  localparam int STEP_MIN = 12499;
  localparam int LAT_MIN = 27500;
  localparam int UV_MIN = 31240;
  int gapCnt_r;
  int runCnt_r;
  int uvCnt_r;
  logic uvPrev_r;
  logic maskBit_r;
  // Cycle counters for the timing relations
  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      gapCnt_r <= 0;
      runCnt_r <= 0;
      uvCnt_r <= 0;
      uvPrev_r <= 1'b0;
      maskBit_r <= 1'b0;
    end else begin
      gapCnt_r <= $changed(vTarget) ? 0 : gapCnt_r + 1;
      runCnt_r <= runPin ? runCnt_r + 1 : 0;
      uvCnt_r <= (uvRaw != uvPrev_r) ? 0 : uvCnt_r + 1;
      uvPrev_r <= uvRaw;
      if (regWr && regAddr == `ORS_A_MASK) begin
        maskBit_r <= regWrData[4];
      end
    end
  end
  default clocking @(posedge sysClk); endclocking
  default disable iff (!rstn);
  chk_target_step_gap: assert property ($changed(vTarget) && vTarget != 16'h0000 |-> gapCnt_r >= STEP_MIN)
    else $error("target stepped too fast");
  chk_start_latency: assert property ($rose(stageOn) |-> runCnt_r >= LAT_MIN)
    else $error("stage enabled before latency");
  chk_fault_all_off: assert property (railFault [*5] |-> !stageOn && phaseEnable == 8'h00)
    else $error("phases still on after fault");
  chk_lockloss_alert: assert property ($fell(pllLocked) && stageOn && !maskBit_r |-> ##[2:6] alertLowOe)
    else $error("alert not raised on lock loss");
  chk_flag_clear: assert property (regWr && regAddr == `ORS_A_STATMFR && regWrData[4] && pllLocked
    && $past(pllLocked, 3) |=> ##1 !alertLowOe)
    else $error("alert stays after clear");
  chk_read_idle: assert property (!$past(regRd) |-> regRdData == 16'h0000)
    else $error("read data outside read slot");
  chk_phase_field: assert property (regWr && regAddr == `ORS_A_PHASE
    |=> ##1 phaseArrangement == $past(regWrData[2:0], 2))
    else $error("arrangement not taken");
  chk_freq_load: assert property (regWr && regAddr == `ORS_A_FREQ
    |=> ##1 freqSelect == $past(regWrData, 2))
    else $error("frequency not taken");
  chk_uv_deglitch: assert property ($changed(uvFaultOut) |-> uvCnt_r >= UV_MIN)
    else $error("undervoltage output not filtered");
  cover property ($rose(stageOn));
  cover property ($rose(alertLowOe));
  cover property ($rose(uvFaultOut));
endmodule // ors_ramp_checker

bind ors_output_ramp_sequencer ors_ramp_checker i_ors_ramp_checker (.sysClk, .rstn, .regAddr, .regWrData, .regWr,
  .regRd, .regRdData, .runPin, .railFault, .pllLocked, .uvRaw, .vTarget, .stageOn, .phaseEnable, .phaseArrangement,
  .freqSelect, .alertLowOe, .uvFaultOut);

// *** ors_peer_model.sv ***
`timescale 1ns/1ns
// ------------------------------------------------------------
// Peer controller driving the shared sync line
// ------------------------------------------------------------
module ors_peer_model (
  input wire drive,
  output logic syncIn
);
  // Sole clock source on the line, 500 kHz; pull-up holds it high when idle
  initial begin
    syncIn = 1'b1;
    forever begin
      if (drive) begin
        syncIn = 1'b0;
        #1000;
      end
      syncIn = 1'b1;
      #1000;
    end
  end
endmodule // ors_peer_model

// *** test_output_ramp_sequencer.sv ***
`timescale 1ns/1ns
`include "ors_consts.vh"
// ------------------------------------------------------------
// Testbench
// ------------------------------------------------------------
module test_output_ramp_sequencer;
  logic sysClk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic busStop = 1'b0;
  logic runPin = 1'b0;
  logic railFault = 1'b0;
  logic pllLocked = 1'b1;
  logic uvRaw = 1'b0;
  logic syncOn = 1'b0;
  logic pwmClk = 1'b0;
  wire syncIn;
  wire [15:0] regRdData, vTarget, freqSelect;
  wire [7:0] phaseEnable;
  wire [2:0] phaseArrangement;
  wire stageOn, useExtSync, alertLowOe, uvFaultOut;
  wire pgOut, pgOe, master_clock_output, alertOut;
  int bad_count = 0;
  int cmp_count = 0;
  logic [15:0] v;
  int n;
  ors_peer_model i_ors_peer_model (.drive(syncOn), .syncIn(syncIn));
  ors_output_ramp_sequencer i_ors_output_ramp_sequencer (.sysClk(sysClk), .rstn(rstn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .busStop(busStop), .runPin(runPin),
    .railFault(railFault), .syncIn(syncIn), .pllLocked(pllLocked), .uvRaw(uvRaw), .powerGood0(1'b1),
    .pwmClkInt(pwmClk), .vTarget(vTarget), .stageOn(stageOn), .phaseEnable(phaseEnable),
    .phaseArrangement(phaseArrangement), .freqSelect(freqSelect), .useExtSync(useExtSync),
    .channelZeroPowerGoodOut(pgOut), .channelZeroPowerGoodOe(pgOe), .clkDriveOut(master_clock_output), .alertLowOut(alertOut),
    .alertLowOe(alertLowOe),
    .uvFaultOut(uvFaultOut));
  // Clock, 8 ns period
  initial begin
    forever #4 sysClk = ~sysClk;
  end
  // Shared helpers
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sysClk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sysClk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sysClk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sysClk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Scenarios
  task automatic t_regs;
    rd(`ORS_A_FREQ, v); chk("freq reset", 16'h0226, v);
    rd(`ORS_A_TARGET, v); chk("target reset", 16'h0400, v);
    rd(4'hF, v); chk("unmapped read", 16'h0000, v);
    wr(`ORS_A_PHASE, 16'h000B);
    wr(`ORS_A_FREQ, 16'h0300);
    pwmClk <= 1'b1;
    @(posedge sysClk);
    #1 chk("arrangement", 16'h0003, {13'h0, phaseArrangement});
    chk("freq select", 16'h0300, freqSelect);
    chk("clock out", 16'h0003, {14'h0, pgOut, pgOe});
    syncOn <= 1'b1; repeat (4500) @(posedge sysClk);
    #1 chk("sync used", 16'h0001, {15'h0, useExtSync});
    syncOn <= 1'b0; repeat (4500) @(posedge sysClk);
    #1 chk("sync dropped", 16'h0000, {15'h0, useExtSync});
  endtask
  task automatic t_turnon;
    wr(`ORS_A_RATE, `ORS_RATE_SKIP);
    wr(`ORS_A_CTRL, 16'h0001);
    @(posedge sysClk) busStop <= 1'b1;
    @(posedge sysClk) busStop <= 1'b0;
    runPin <= 1'b1;
    for (n = 0; n < 60000 && stageOn !== 1'b1; n++) begin
      @(posedge sysClk);
      #1;
    end
    if (stageOn !== 1'b1) begin
      bad_count++;
      $display("Error turn-on timeout expected %h seen %h", 1'b1, stageOn);
      summarize;
    end
    chk("turn-on window", 16'h0001, {15'h0, n >= 27500 && n <= 40000});
    chk("target jump", `ORS_RST_TARGET, vTarget);
    rd(`ORS_A_STATE, v); chk("run state", {12'h0, 1'b1, `ORS_S_RUN}, v & 16'h000F);
    chk("clock drive off", 16'h0000, {15'h0, master_clock_output});
  endtask
  task automatic t_lock;
    pllLocked <= 1'b0; repeat (6) @(posedge sysClk);
    rd(`ORS_A_STATMFR, v); chk("lock flag", 16'h0010, v);
    chk("alert", 16'h0001, {14'h0, alertOut, alertLowOe});
    pllLocked <= 1'b1; repeat (4) @(posedge sysClk);
    wr(`ORS_A_STATMFR, 16'h0010); rd(`ORS_A_STATMFR, v); chk("flag cleared", 16'h0000, v);
    wr(`ORS_A_MASK, 16'h0010); pllLocked <= 1'b0; repeat (6) @(posedge sysClk);
    #1 chk("masked alert", 16'h0000, {15'h0, alertLowOe});
    pllLocked <= 1'b1;
  endtask
  task automatic t_fault;
    railFault <= 1'b1; repeat (5) @(posedge sysClk);
    #1 chk("stage off", 16'h0000, {7'h0, stageOn, phaseEnable});
    railFault <= 1'b0;
  endtask
  task automatic t_uv;
    uvRaw <= 1'b1; repeat (100) @(posedge sysClk);
    uvRaw <= 1'b0; repeat (200) @(posedge sysClk);
    #1 chk("uv glitch", 16'h0000, {15'h0, uvFaultOut});
    uvRaw <= 1'b1; repeat (31300) @(posedge sysClk);
    #1 chk("uv held", 16'h0001, {15'h0, uvFaultOut});
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge sysClk);
    rstn <= 1'b1;
    t_regs;
    t_turnon;
    t_lock;
    t_fault;
    t_uv;
    summarize;
  end
endmodule // test_output_ramp_sequencer
